// file: logic/cstsup_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef CSTSUP_REGS_SVH
`define CSTSUP_REGS_SVH

// =====================================================================
// register offsets
`define CSTSUP_CTRL_ADDR 4'h0
`define CSTSUP_TEMP_ADDR 4'h1
`define CSTSUP_COMP_ADDR 4'h2
`define CSTSUP_TIMER_ADDR 4'h3
`define CSTSUP_STAT_ADDR 4'h4
`define CSTSUP_LB_CNT_ADDR 4'h5
`define CSTSUP_BK_CNT_ADDR 4'h6

// =====================================================================
// control, temperature, compensation and timer fields
`define CSTSUP_CTRL_CHG_ENABLE 0
`define CSTSUP_CTRL_SW_OVERRIDE 1
`define CSTSUP_CTRL_HIZ 2
`define CSTSUP_CTRL_STOP_ON_FULL 3
`define CSTSUP_CTRL_RECH_150 4
`define CSTSUP_CTRL_RESET 8'h00
`define CSTSUP_TEMP_PROFILE 0
`define CSTSUP_TEMP_MON_DIS 1
`define CSTSUP_TEMP_COLD_SEL 2
`define CSTSUP_TEMP_HOT_LSB 3
`define CSTSUP_TEMP_RESET 8'h00
`define CSTSUP_COMP_RES_LSB 0
`define CSTSUP_COMP_CLAMP_LSB 3
`define CSTSUP_COMP_RESET 8'h00
`define CSTSUP_TMR_SEL_LSB 0
`define CSTSUP_TMR_KILL 5
`define CSTSUP_TMR_PAUSE 6
`define CSTSUP_TMR_RESET 8'h00

// =====================================================================
// compensation scales
`define CSTSUP_CLAMP_STEP_MV 16'd60
`define CSTSUP_RES_STEP_MOHM 16'd20
`define CSTSUP_HOT_DISABLE 2'b11

// =====================================================================
// timing
`define CSTSUP_CLK_HZ 50000000
`define CSTSUP_TICK_MS 1000
`define CSTSUP_TICK_CYCLES ((`CSTSUP_CLK_HZ / 1000) * `CSTSUP_TICK_MS)
`define CSTSUP_LB_MINUTES 120
`define CSTSUP_BULK_MIN_MINUTES 30
`define CSTSUP_TICKS_PER_MINUTE (60000 / `CSTSUP_TICK_MS)

`endif

// file: logic/cstsup_pkg.sv
// types of the charge safety timer supervisor
`default_nettype none
package cstsup_pkg;
  typedef enum logic [6:0] {
    CS_RESET = 7'h01,
    CS_PRECH = 7'h02,
    CS_PRECH_SUSP = 7'h04,
    CS_BULK = 7'h08,
    CS_FULL = 7'h10,
    CS_DONE = 7'h20,
    CS_FAULT = 7'h40
  } cstsup_state_t;
endpackage
`default_nettype wire

// file: logic/cstsup_top.sv
// charge safety timer supervisor: temperature gate, compensation, termination, timers
//
// Implementation choices: the address map and the strobed register port.
`default_nettype none
`include "cstsup_regs.svh"

module cstsup_top #(
  parameter int unsigned TICK_CYCLES = `CSTSUP_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pins and analogue comparator status (asynchronous)
  input wire logic charge_enable_pin,
  input wire logic temp_above_hot_55,
  input wire logic temp_above_hot_60,
  input wire logic temp_above_hot_65,
  input wire logic temp_below_cold_0,
  input wire logic temp_below_cold_m10,
  input wire logic temp_zone_mild,
  input wire logic vbat_below_low,
  input wire logic vbat_at_term,
  input wire logic ichg_below_term,
  input wire logic vbat_below_recharge,
  input wire logic loop_iin_active,
  input wire logic loop_vin_active,
  input wire logic loop_die_active,
  // charge current from the charge loop, in mA
  input wire logic [15:0] ichg_ma,
  // outputs to the power stage
  output logic charge_on,
  output logic recharge_150,
  output logic [15:0] term_boost_mv,
  output logic [6:0] charge_state,
  output logic charge_fault
);

  // =====================================================================
  // input synchronisers
  localparam int NS = 14;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {charge_enable_pin, temp_above_hot_55, temp_above_hot_60, temp_above_hot_65,
                temp_below_cold_0, temp_below_cold_m10, temp_zone_mild, vbat_below_low,
                vbat_at_term, ichg_below_term, vbat_below_recharge, loop_iin_active,
                loop_vin_active, loop_die_active};
      sync2 <= sync1;
    end
  end
  logic pin_en, hot55, hot60, hot65, cold0, coldm10, mild, low_bat;
  logic at_term, i_low, below_rech, l_iin, l_vin, l_die;
  assign {pin_en, hot55, hot60, hot65, cold0, coldm10, mild, low_bat,
          at_term, i_low, below_rech, l_iin, l_vin, l_die} = sync2;

  // =====================================================================
  // register file
  logic [7:0] ctrl, temp_cfg, comp_cfg, tmr_cfg;
  logic [7:0] next_ctrl, next_temp_cfg, next_comp_cfg, next_tmr_cfg, next_rdata;
  logic [7:0] stat_byte;
  logic [15:0] lb_cnt, bk_cnt;

  always_comb begin
    next_ctrl = ctrl;
    next_temp_cfg = temp_cfg;
    next_comp_cfg = comp_cfg;
    next_tmr_cfg = tmr_cfg;
    next_rdata = 8'h00;
    if (reg_wr) begin
      if (reg_addr == `CSTSUP_CTRL_ADDR) begin
        next_ctrl = reg_wdata;
      end else if (reg_addr == `CSTSUP_TEMP_ADDR) begin
        next_temp_cfg = reg_wdata;
      end else if (reg_addr == `CSTSUP_COMP_ADDR) begin
        next_comp_cfg = reg_wdata;
      end else if (reg_addr == `CSTSUP_TIMER_ADDR) begin
        next_tmr_cfg = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_addr == `CSTSUP_CTRL_ADDR) begin
        next_rdata = ctrl;
      end else if (reg_addr == `CSTSUP_TEMP_ADDR) begin
        next_rdata = temp_cfg;
      end else if (reg_addr == `CSTSUP_COMP_ADDR) begin
        next_rdata = comp_cfg;
      end else if (reg_addr == `CSTSUP_TIMER_ADDR) begin
        next_rdata = tmr_cfg;
      end else if (reg_addr == `CSTSUP_STAT_ADDR) begin
        next_rdata = stat_byte;
      end else if (reg_addr == `CSTSUP_LB_CNT_ADDR) begin
        next_rdata = lb_cnt[7:0];
      end else if (reg_addr == `CSTSUP_BK_CNT_ADDR) begin
        next_rdata = bk_cnt[7:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `CSTSUP_CTRL_RESET;
      temp_cfg <= `CSTSUP_TEMP_RESET;
      comp_cfg <= `CSTSUP_COMP_RESET;
      tmr_cfg <= `CSTSUP_TMR_RESET;
      reg_rdata <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      temp_cfg <= next_temp_cfg;
      comp_cfg <= next_comp_cfg;
      tmr_cfg <= next_tmr_cfg;
      reg_rdata <= next_rdata;
    end
  end

  // =====================================================================
  // temperature gate
  logic mon_on, simple, hot_trip, cold_trip, temp_out, mild_zone;
  logic [1:0] hot_sel;
  assign hot_sel = temp_cfg[`CSTSUP_TEMP_HOT_LSB +: 2];
  assign mon_on = !temp_cfg[`CSTSUP_TEMP_MON_DIS];
  assign simple = temp_cfg[`CSTSUP_TEMP_PROFILE];
  always_comb begin
    hot_trip = 1'b0;
    if (hot_sel == 2'b00) begin
      hot_trip = hot55;
    end else if (hot_sel == 2'b01) begin
      hot_trip = hot60;
    end else if (hot_sel == 2'b10) begin
      hot_trip = hot65;
    end
    if (!simple) begin
      hot_trip = hot60;
    end
  end
  // cold select 1 means minus 10; zoned profile uses 0 degrees
  assign cold_trip = (simple && temp_cfg[`CSTSUP_TEMP_COLD_SEL]) ? coldm10 : cold0;
  assign temp_out = mon_on && (hot_trip || cold_trip);
  assign mild_zone = mon_on && !simple && mild;

  // =====================================================================
  // path compensation
  function automatic logic [15:0] cstsup_min16(input logic [15:0] a, input logic [15:0] b);
    cstsup_min16 = (a < b) ? a : b;
  endfunction
  logic [31:0] ir_prod;
  logic [15:0] ir_mv, clamp_mv, next_boost;
  always_comb begin
    ir_prod = 32'(ichg_ma) * 32'(`CSTSUP_RES_STEP_MOHM) * 32'(comp_cfg[2:0]);
    ir_mv = (ir_prod / 32'd1000) > 32'h0000ffff ? 16'hffff : 16'(ir_prod / 32'd1000);
    clamp_mv = 16'(`CSTSUP_CLAMP_STEP_MV * 16'(comp_cfg[`CSTSUP_COMP_CLAMP_LSB +: 3]));
    next_boost = cstsup_min16(ir_mv, clamp_mv);
  end

  // =====================================================================
  // charge state machine
  cstsup_pkg::cstsup_state_t state, next_state;
  logic chg_req, loops, lb_exp, bk_exp;
  assign chg_req = (ctrl[`CSTSUP_CTRL_SW_OVERRIDE] ? ctrl[`CSTSUP_CTRL_CHG_ENABLE] : pin_en)
                   && !ctrl[`CSTSUP_CTRL_HIZ];
  assign loops = l_iin || l_vin || l_die;
  always_comb begin
    next_state = state;
    case (state)
      cstsup_pkg::CS_RESET: begin
        if (chg_req) begin
          next_state = low_bat ? cstsup_pkg::CS_PRECH : cstsup_pkg::CS_BULK;
        end
      end
      cstsup_pkg::CS_PRECH: begin
        if (lb_exp) begin
          next_state = cstsup_pkg::CS_FAULT;
        end else if (temp_out) begin
          next_state = cstsup_pkg::CS_PRECH_SUSP;
        end else if (!low_bat) begin
          next_state = cstsup_pkg::CS_BULK;
        end
      end
      cstsup_pkg::CS_PRECH_SUSP: begin
        if (!temp_out) begin
          next_state = cstsup_pkg::CS_PRECH;
        end
      end
      cstsup_pkg::CS_BULK: begin
        if (bk_exp) begin
          next_state = cstsup_pkg::CS_FAULT;
        end else if (at_term && i_low && !loops && !temp_out) begin
          next_state = ctrl[`CSTSUP_CTRL_STOP_ON_FULL] ? cstsup_pkg::CS_DONE
                                                        : cstsup_pkg::CS_FULL;
        end
      end
      cstsup_pkg::CS_FULL: begin
        next_state = cstsup_pkg::CS_FULL;
      end
      cstsup_pkg::CS_DONE: begin
        if (below_rech) begin
          next_state = cstsup_pkg::CS_BULK;
        end
      end
      cstsup_pkg::CS_FAULT: begin
        if (tmr_cfg[`CSTSUP_TMR_KILL]) begin
          next_state = cstsup_pkg::CS_RESET;
        end
      end
      default: begin
        next_state = cstsup_pkg::CS_RESET;
      end
    endcase
    if (!chg_req) begin
      next_state = cstsup_pkg::CS_RESET;
    end
  end

  // =====================================================================
  // safety timers
  logic [31:0] presc, next_presc;
  logic half_phase, next_half_phase;
  logic [15:0] next_lb_cnt, next_bk_cnt;
  logic [15:0] bk_limit;
  logic tick, timers_clr, frozen, lb_run, bk_run;
  // steps of 30 minutes: code 0 is 30 min, code 31 is 16 hours
  assign bk_limit = 16'((32'(tmr_cfg[`CSTSUP_TMR_SEL_LSB +: 5]) + 32'd1)
                        * `CSTSUP_BULK_MIN_MINUTES * `CSTSUP_TICKS_PER_MINUTE);
  assign timers_clr = (state == cstsup_pkg::CS_RESET) || tmr_cfg[`CSTSUP_TMR_KILL]
                      || (state == cstsup_pkg::CS_FULL) || (state == cstsup_pkg::CS_DONE)
                      || !chg_req;
  assign frozen = tmr_cfg[`CSTSUP_TMR_PAUSE] || temp_out;
  assign lb_exp = lb_cnt >= 16'(`CSTSUP_LB_MINUTES * `CSTSUP_TICKS_PER_MINUTE);
  assign bk_exp = bk_cnt >= bk_limit;
  always_comb begin
    next_presc = presc + 32'd1;
    tick = 1'b0;
    if (presc >= TICK_CYCLES - 1) begin
      next_presc = 32'd0;
      tick = 1'b1;
    end
    next_half_phase = half_phase ^ tick;
    lb_run = tick && (!loops || half_phase);
    bk_run = tick && (!(loops || mild_zone) || half_phase);
    next_lb_cnt = lb_cnt;
    next_bk_cnt = bk_cnt;
    if (timers_clr) begin
      next_lb_cnt = 16'h0000;
      next_bk_cnt = 16'h0000;
    end else if (!frozen) begin
      if (low_bat && state == cstsup_pkg::CS_PRECH) begin
        next_bk_cnt = 16'h0000;
        if (lb_run && !lb_exp) begin
          next_lb_cnt = lb_cnt + 16'h0001;
        end
      end else if (state == cstsup_pkg::CS_BULK) begin
        next_lb_cnt = 16'h0000;
        if (bk_run && !bk_exp) begin
          next_bk_cnt = bk_cnt + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= cstsup_pkg::CS_RESET;
      presc <= 32'd0;
      half_phase <= 1'b0;
      lb_cnt <= 16'h0000;
      bk_cnt <= 16'h0000;
      charge_on <= 1'b0;
      recharge_150 <= 1'b0;
      term_boost_mv <= 16'h0000;
      charge_state <= 7'h01;
      charge_fault <= 1'b0;
    end else begin
      state <= next_state;
      presc <= next_presc;
      half_phase <= next_half_phase;
      lb_cnt <= next_lb_cnt;
      bk_cnt <= next_bk_cnt;
      charge_on <= ((next_state == cstsup_pkg::CS_PRECH) || (next_state == cstsup_pkg::CS_BULK)
                    || (next_state == cstsup_pkg::CS_FULL))
                   && !temp_out;
      recharge_150 <= ctrl[`CSTSUP_CTRL_RECH_150];
      term_boost_mv <= next_boost;
      charge_state <= 7'(next_state);
      charge_fault <= next_state == cstsup_pkg::CS_FAULT;
    end
  end
  assign stat_byte = {charge_fault, temp_out, state[5:0]};

  // =====================================================================
  // checks
  kill_clears_a: assert property (@(posedge clk) disable iff (rst)
    tmr_cfg[`CSTSUP_TMR_KILL] |=> (lb_cnt == 16'h0000 && bk_cnt == 16'h0000))
    else $error("kill did not clear timers");
  pause_holds_a: assert property (@(posedge clk) disable iff (rst)
    (tmr_cfg[`CSTSUP_TMR_PAUSE] && !timers_clr) |=> ($stable(lb_cnt) && $stable(bk_cnt)))
    else $error("pause did not hold count");
  temp_freeze_a: assert property (@(posedge clk) disable iff (rst)
    (temp_out && !timers_clr) |=> ($stable(lb_cnt) && $stable(bk_cnt)))
    else $error("timer ran while temperature out");
  no_full_loop_a: assert property (@(posedge clk) disable iff (rst)
    (state == cstsup_pkg::CS_BULK && loops) |=> state != cstsup_pkg::CS_FULL
      && state != cstsup_pkg::CS_DONE)
    else $error("terminated under regulation");
  done_no_charge_a: assert property (@(posedge clk) disable iff (rst)
    state == cstsup_pkg::CS_DONE |-> !charge_on)
    else $error("charging while done");
  bulk_fault_a: assert property (@(posedge clk) disable iff (rst)
    (state == cstsup_pkg::CS_BULK && bk_exp && chg_req) |=> state == cstsup_pkg::CS_FAULT)
    else $error("bulk expiry missed");
  lb_fault_a: assert property (@(posedge clk) disable iff (rst)
    (state == cstsup_pkg::CS_PRECH && lb_exp && chg_req) |=> state == cstsup_pkg::CS_FAULT)
    else $error("low battery expiry missed");
  boost_clamp_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> term_boost_mv <= $past(clamp_mv))
    else $error("boost above ceiling");
  full_reset_a: assert property (@(posedge clk) disable iff (rst)
    state == cstsup_pkg::CS_FULL |=> bk_cnt == 16'h0000)
    else $error("timer not reset in full hold");
  temp_off_a: assert property (@(posedge clk) disable iff (rst)
    temp_out |=> !charge_on)
    else $error("charging while temperature out");
  fault_no_charge_a: assert property (@(posedge clk) disable iff (rst)
    charge_fault |-> !charge_on)
    else $error("charging while in fault");
  lb_bulk_held_a: assert property (@(posedge clk) disable iff (rst)
    (state == cstsup_pkg::CS_BULK && !timers_clr && !frozen) |=> lb_cnt == 16'h0000)
    else $error("low battery timer ran in bulk");
  prech_bk_held_a: assert property (@(posedge clk) disable iff (rst)
    (state == cstsup_pkg::CS_PRECH && low_bat && !timers_clr && !frozen) |=> bk_cnt == 16'h0000)
    else $error("bulk timer ran in precharge");
  full_stays_a: assert property (@(posedge clk) disable iff (rst)
    (state == cstsup_pkg::CS_FULL && chg_req) |=> state == cstsup_pkg::CS_FULL)
    else $error("full hold left while charging");
  hot_off_a: assert property (@(posedge clk) disable iff (rst)
    (simple && hot_sel == `CSTSUP_HOT_DISABLE && !cold_trip) |-> !temp_out)
    else $error("hot suspend while disabled");
  done_recharge_a: assert property (@(posedge clk) disable iff (rst)
    (state == cstsup_pkg::CS_DONE && below_rech && chg_req) |=> state == cstsup_pkg::CS_BULK)
    else $error("recharge missed");
  mon_off_a: assert property (@(posedge clk) disable iff (rst)
    temp_cfg[`CSTSUP_TEMP_MON_DIS] |-> !temp_out)
    else $error("temperature used while monitor off");

endmodule
`default_nettype wire

// file: testbench/cstsup_batt_model.sv
// battery and comparator model on the far side of the supervisor
`default_nettype none
module cstsup_batt_model #(
  parameter int LOW_MV = 6000,
  parameter int TERM_MV = 8400,
  parameter int ITERM_MA = 200
) (
  // battery conditions from the bench, hysteresis select from the supervisor
  input var int temp_c,
  input var int vbat_mv,
  input wire logic [15:0] ichg_ma,
  input wire logic recharge_150,
  // comparator levels
  output logic temp_above_hot_55,
  output logic temp_above_hot_60,
  output logic temp_above_hot_65,
  output logic temp_below_cold_0,
  output logic temp_below_cold_m10,
  output logic vbat_below_low,
  output logic vbat_at_term,
  output logic ichg_below_term,
  output logic vbat_below_recharge
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // thresholds
  assign temp_above_hot_55 = temp_c > 55;
  assign temp_above_hot_60 = temp_c > 60;
  assign temp_above_hot_65 = temp_c > 65;
  assign temp_below_cold_0 = temp_c < 0;
  assign temp_below_cold_m10 = temp_c < -10;
  assign vbat_below_low = vbat_mv < LOW_MV;
  assign vbat_at_term = vbat_mv >= TERM_MV;
  assign ichg_below_term = ichg_ma < ITERM_MA;
  assign vbat_below_recharge = vbat_mv < TERM_MV - (recharge_150 ? 150 : 100);
endmodule
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench of the charge safety timer supervisor
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 2;
  logic clk, rst, reg_wr, reg_rd, charge_enable_pin, temp_zone_mild;
  logic loop_iin_active, loop_vin_active, loop_die_active;
  logic temp_above_hot_55, temp_above_hot_60, temp_above_hot_65;
  logic temp_below_cold_0, temp_below_cold_m10, vbat_below_low;
  logic vbat_at_term, ichg_below_term, vbat_below_recharge;
  logic charge_on, recharge_150, charge_fault;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [15:0] ichg_ma, term_boost_mv;
  logic [6:0] charge_state;
  int temp_c, vbat_mv, err_total, check_count;
  logic [7:0] tcfg [11] = '{8'h01, 8'h00, 8'h09, 8'h09, 8'h19, 8'h01, 8'h05, 8'h05, 8'h03,
                            8'h11, 8'h11};
  int tdeg [11] = '{57, 57, 57, 62, 70, -5, -5, -12, 70, 62, 67};
  logic [10:0] tsus = 11'h4a9;

  cstsup_top #(.TICK_CYCLES(TK)) dut_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .charge_enable_pin, .temp_above_hot_55, .temp_above_hot_60,
    .temp_above_hot_65, .temp_below_cold_0, .temp_below_cold_m10, .temp_zone_mild,
    .vbat_below_low, .vbat_at_term, .ichg_below_term, .vbat_below_recharge,
    .loop_iin_active, .loop_vin_active, .loop_die_active, .ichg_ma, .charge_on,
    .recharge_150, .term_boost_mv, .charge_state, .charge_fault);
  cstsup_batt_model model_u (.temp_c, .vbat_mv, .ichg_ma, .recharge_150,
    .temp_above_hot_55, .temp_above_hot_60, .temp_above_hot_65, .temp_below_cold_0,
    .temp_below_cold_m10, .vbat_below_low, .vbat_at_term, .ichg_below_term,
    .vbat_below_recharge);

  // ==========================================================
  // helpers
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task automatic settle();
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic st(input logic [6:0] s, input logic on, input string what);
    settle();
    chk(16'(charge_state), 16'(s), what);
    chk(16'(charge_on), 16'(on), what);
  endtask
  // counter step over a fixed window of 102 cycles
  task automatic span(input logic [3:0] a, input int lo, input int hi);
    logic [7:0] v0;
    rd(a);
    v0 = rv;
    repeat (100) @(posedge clk);
    rd(a);
    rv = rv - v0;
    check_count++;
    if ($isunknown(rv) || rv < lo || rv > hi) begin
      err_total++;
      $display("BAD %0t count step %0d at %h", $time, rv, a);
    end
  endtask
  task automatic waitf(input int n);
    for (int k = 0; k < n && charge_fault !== 1'b1; k++) @(posedge clk);
    #1;
    chk(16'(charge_fault), 16'h0001, "fault flag");
    chk(16'(charge_state), 16'h0040, "fault state");
    chk(16'(charge_on), 16'h0000, "fault no charge");
  endtask

  // ==========================================================
  // scenarios
  task automatic reset_values();
    #1;
    chk(16'(charge_state), 16'h0001, "reset state");
    chk(16'({charge_on, charge_fault, recharge_150}), 16'h0000, "reset flags");
    chk(term_boost_mv, 16'h0000, "reset boost");
    for (int i = 0; i < 4; i++) begin
      rd(4'(i));
      chk(16'(rv), 16'h0000, "reg reset");
    end
    wr(4'h1, 8'h1d);
    rd(4'h1);
    chk(16'(rv), 16'h001d, "temp readback");
    wr(4'h3, 8'h1f);
    rd(4'h3);
    chk(16'(rv), 16'h001f, "timer readback");
    wr(4'h3, 8'h00);
    rd(4'hf);
    chk(16'(rv), 16'h0000, "unmapped read");
  endtask
  task automatic comp_boost();
    wr(4'h2, 8'h3f);
    rd(4'h2);
    chk(16'(rv), 16'h003f, "comp readback");
    settle();
    chk(term_boost_mv, 16'h008c, "boost by current");
    ichg_ma <= 16'h0fa0;
    settle();
    chk(term_boost_mv, 16'h01a4, "boost at ceiling");
    wr(4'h2, 8'h0f);
    settle();
    chk(term_boost_mv, 16'h003c, "boost low ceiling");
    ichg_ma <= 16'h03e8;
    wr(4'h0, 8'h10);
    settle();
    chk(16'(recharge_150), 16'h0001, "hyst 150");
    wr(4'h0, 8'h00);
  endtask
  task automatic temp_gate();
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h03);
    st(7'h02, 1'b1, "precharge");
    for (int i = 0; i < 11; i++) begin
      wr(4'h1, tcfg[i]);
      temp_c <= tdeg[i];
      st(tsus[i] ? 7'h04 : 7'h02, !tsus[i], "temp gate");
    end
    wr(4'h1, 8'h01);
    temp_c <= 25;
  endtask
  task automatic lowbat_timer();
    st(7'h02, 1'b1, "precharge");
    span(4'h5, 47, 55);
    span(4'h6, 0, 0);
    for (int i = 0; i < 3; i++) begin
      {loop_die_active, loop_vin_active, loop_iin_active} <= 3'(1 << i);
      settle();
      span(4'h5, 22, 29);
    end
    {loop_die_active, loop_vin_active, loop_iin_active} <= 3'h0;
    wr(4'h3, 8'h40);
    span(4'h5, 0, 0);
    wr(4'h3, 8'h00);
    temp_c <= 70;
    st(7'h04, 1'b0, "hot suspend");
    rd(4'h4);
    chk(16'(rv), 16'h0044, "status suspend");
    span(4'h5, 0, 0);
    temp_c <= 25;
    wr(4'h3, 8'h20);
    rd(4'h5);
    chk(16'(rv), 16'h0000, "kill clears");
    wr(4'h3, 8'h00);
  endtask
  task automatic bulk_timer();
    vbat_mv <= 7000;
    st(7'h08, 1'b1, "bulk");
    rd(4'h5);
    chk(16'(rv), 16'h0000, "lowbat held");
    span(4'h6, 47, 55);
    wr(4'h1, 8'h00);
    temp_zone_mild <= 1'b1;
    settle();
    span(4'h6, 22, 29);
    temp_zone_mild <= 1'b0;
    wr(4'h1, 8'h01);
    loop_die_active <= 1'b1;
    settle();
    span(4'h6, 22, 29);
    loop_die_active <= 1'b0;
    temp_c <= 70;
    st(7'h08, 1'b0, "bulk hot suspend");
    span(4'h6, 0, 0);
    temp_c <= 25;
  endtask
  task automatic termination();
    ichg_ma <= 16'h07d0;
    vbat_mv <= 8400;
    st(7'h08, 1'b1, "high current");
    loop_vin_active <= 1'b1;
    ichg_ma <= 16'h0064;
    st(7'h08, 1'b1, "regulating");
    loop_vin_active <= 1'b0;
    st(7'h10, 1'b1, "full hold");
    rd(4'h6);
    chk(16'(rv), 16'h0000, "full resets bulk");
    charge_enable_pin <= 1'b1;
    st(7'h10, 1'b1, "full stays");
    wr(4'h0, 8'h00);
    st(7'h10, 1'b1, "pin holds charge");
    charge_enable_pin <= 1'b0;
    st(7'h01, 1'b0, "charge exit");
    wr(4'h0, 8'h1b);
    st(7'h20, 1'b0, "done");
    vbat_mv <= 8280;
    st(7'h20, 1'b0, "inside 150 hyst");
    wr(4'h0, 8'h0b);
    st(7'h08, 1'b1, "recharge");
  endtask
  task automatic expiry();
    ichg_ma <= 16'h03e8;
    vbat_mv <= 7000;
    wr(4'h3, 8'h20);
    wr(4'h3, 8'h00);
    repeat (3400) @(posedge clk);
    chk(16'(charge_fault), 16'h0000, "bulk early");
    waitf(400);
    rd(4'h4);
    chk(16'(rv), 16'h0080, "status fault");
    wr(4'h3, 8'h20);
    settle();
    chk(16'(charge_fault), 16'h0000, "bulk fault cleared");
    wr(4'h0, 8'h00);
    vbat_mv <= 5000;
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h03);
    repeat (14200) @(posedge clk);
    chk(16'(charge_fault), 16'h0000, "lowbat early");
    waitf(600);
    wr(4'h3, 8'h20);
    settle();
    chk(16'(charge_fault), 16'h0000, "lowbat fault cleared");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, charge_enable_pin, temp_zone_mild} = 4'h0;
    {loop_iin_active, loop_vin_active, loop_die_active} = 3'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    ichg_ma = 16'h03e8;
    temp_c = 25;
    vbat_mv = 5000;
    err_total = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reset_values();
    comp_boost();
    temp_gate();
    lowbat_timer();
    bulk_timer();
    termination();
    expiry();
    give_verdict();
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
